/* rtl/dag_map.vh */
// constants for the dual data address generators
`ifndef DDA_MAP_VH
`define DDA_MAP_VH
`define DDA_AW       14
`define DDA_SELW     2
`define DDA_NSLOT    8
`define DDA_NGEN     2
`define DDA_ZERO_AW  14'h0000
`define DDA_ZERO_SEL 2'h0
`define DDA_BIT_CLR  1'h0
`define DDA_BANK_DM  1'h0
`define DDA_BANK_PM  1'h1
`define DDA_GEN_DS   1'h0
`define DDA_GEN_DU   1'h1
`define DDA_LD_NONE  2'h0
`define DDA_LD_PTR   2'h1
`define DDA_LD_MOD   2'h2
`define DDA_LD_LEN   2'h3
`endif

/* rtl/dag_dual.v */
// dual data address generators: pointers, modify, length, bit reverse
`timescale 1ns/1ps
`include "dag_map.vh"
// Notes on behaviour
// - four selectable pointers in each generator
// - post-modify used pointer by chosen modify
// - length per pointer makes circular buffer
// - first generator: data memory, optional bit reverse
// - second: program or data, never reversed
// - both generators work in same cycle
// - serial ports share circular addressing path
module dda_dual #(
  parameter AW = `DDA_AW
) (
  input  wire                 clk_i,
  input  wire                 reset_i,
  // register loads: ld_sel 1 pointer, 2 modify, 3 length
  input  wire [`DDA_SELW-1:0] ld_sel_i,
  input  wire                 ld_gen_i,
  input  wire [`DDA_SELW-1:0] ld_idx_i,
  input  wire [AW-1:0]        ld_data_i,
  // data side generator request
  input  wire                 ds_req_i,
  input  wire [`DDA_SELW-1:0] ds_ptr_i,
  input  wire [`DDA_SELW-1:0] ds_mod_i,
  input  wire                 ds_bitrev_i,
  // dual side generator request
  input  wire                 du_req_i,
  input  wire [`DDA_SELW-1:0] du_ptr_i,
  input  wire [`DDA_SELW-1:0] du_mod_i,
  input  wire                 du_bank_i,
  // serial port auto transfer, uses data side generator
  input  wire                 sp_req_i,
  input  wire [`DDA_SELW-1:0] sp_ptr_i,
  input  wire [`DDA_SELW-1:0] sp_mod_i,
  output wire [AW-1:0]        data_memory_address_bus_o,
  output wire                 dm_valid_o,
  output wire [AW-1:0]        program_memory_address_bus_o,
  output wire                 pm_valid_o,
  output wire [AW-1:0]        du_dm_address_o,
  output wire                 du_dm_valid_o,
  output wire                 sp_grant_o
);
  localparam SELW  = `DDA_SELW;
  localparam IW    = SELW + 1;
  localparam NSLOT = `DDA_NSLOT;
  localparam NGEN  = `DDA_NGEN;

  // slots 0-3 data side, 4-7 dual side; top index bit = generator
  reg  [AW-1:0]   ptr_r  [0:NSLOT-1];
  reg  [AW-1:0]   mod_r  [0:NSLOT-1];
  reg  [AW-1:0]   len_r  [0:NSLOT-1];
  reg  [AW-1:0]   base_r [0:NSLOT-1];

  // every output leaves from one of these flops
  reg  [AW-1:0]   dm_addr_r;
  reg             dm_valid_r;
  reg  [AW-1:0]   pm_addr_r;
  reg             pm_valid_r;
  reg  [AW-1:0]   du_dm_addr_r;
  reg             du_dm_valid_r;
  reg             sp_grant_r;

  // core wins the data side; serial port must hold its request
  wire            sp_go;
  wire            ds_go;
  wire [SELW-1:0] ds_p;
  wire [SELW-1:0] ds_m;
  assign sp_go = sp_req_i & ~ds_req_i;
  assign ds_go = ds_req_i | sp_go;
  assign ds_p  = ds_req_i ? ds_ptr_i : sp_ptr_i;
  assign ds_m  = ds_req_i ? ds_mod_i : sp_mod_i;

  // slot numbers: generator bit above the two select bits
  wire [IW-1:0]   ds_pi;
  wire [IW-1:0]   ds_mi;
  wire [IW-1:0]   du_pi;
  wire [IW-1:0]   du_mi;
  wire [IW-1:0]   ld_i;
  assign ds_pi = {`DDA_GEN_DS, ds_p};
  assign ds_mi = {`DDA_GEN_DS, ds_m};
  assign du_pi = {`DDA_GEN_DU, du_ptr_i};
  assign du_mi = {`DDA_GEN_DU, du_mod_i};
  assign ld_i  = {ld_gen_i, ld_idx_i};

  // operands of both generators, data side in the low part
  wire [NGEN*AW-1:0] cur_v;
  wire [NGEN*AW-1:0] mod_v;
  wire [NGEN*AW-1:0] len_v;
  wire [NGEN*AW-1:0] base_v;
  wire [NGEN*AW-1:0] nxt_v;
  assign cur_v  = {ptr_r[du_pi], ptr_r[ds_pi]};
  assign mod_v  = {mod_r[du_mi], mod_r[ds_mi]};
  assign len_v  = {len_r[du_pi], len_r[ds_pi]};
  assign base_v = {base_r[du_pi], base_r[ds_pi]};

  // one adder and wrap per generator, so both step together
  genvar g;
  generate
    for (g = 0; g < NGEN; g = g + 1) begin : gen_step
      wire [AW-1:0] cur  = cur_v[g*AW +: AW];
      wire [AW-1:0] modv = mod_v[g*AW +: AW];
      wire [AW-1:0] lenv = len_v[g*AW +: AW];
      wire [AW-1:0] basv = base_v[g*AW +: AW];
      reg  [AW:0]   sum_c;
      reg  [AW:0]   end_c;
      reg  [AW-1:0] nxt_c;
      // modify is two's complement: sign extend before the add
      always @* begin
        sum_c = {`DDA_BIT_CLR, cur} + {modv[AW-1], modv};
        end_c = {`DDA_BIT_CLR, basv} + {`DDA_BIT_CLR, lenv};
        nxt_c = sum_c[AW-1:0];
        if (lenv != `DDA_ZERO_AW) begin
          // a stride longer than the buffer wraps only once
          if (!modv[AW-1] && (sum_c >= end_c)) begin
            nxt_c = sum_c[AW-1:0] - lenv;
          end else if (modv[AW-1] && (sum_c[AW-1:0] < basv)) begin
            nxt_c = sum_c[AW-1:0] + lenv;
          end
        end
      end
      assign nxt_v[g*AW +: AW] = nxt_c;
    end
  endgenerate

  wire [AW-1:0]   ds_cur;
  wire [AW-1:0]   du_cur;
  wire [AW-1:0]   ds_nxt;
  wire [AW-1:0]   du_nxt;
  assign ds_cur = cur_v[AW-1:0];
  assign du_cur = cur_v[NGEN*AW-1:AW];
  assign ds_nxt = nxt_v[AW-1:0];
  assign du_nxt = nxt_v[NGEN*AW-1:AW];

  // mirrored address bits; only the data side owns this path
  wire [AW-1:0]   ds_rev;
  genvar k;
  generate
    for (k = 0; k < AW; k = k + 1) begin : gen_rev
      assign ds_rev[k] = ds_cur[AW-1-k];
    end
  endgenerate

  // reversal only when the core asks, never for a serial transfer
  wire            rev_on;
  wire            ld_ptr;
  wire            ld_mod;
  wire            ld_len;
  assign rev_on = ds_bitrev_i & ds_req_i;
  assign ld_ptr = (ld_sel_i == `DDA_LD_PTR);
  assign ld_mod = (ld_sel_i == `DDA_LD_MOD);
  assign ld_len = (ld_sel_i == `DDA_LD_LEN);

  // pointer file: load comes last so a write wins a collision
  integer jp;
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (jp = 0; jp < NSLOT; jp = jp + 1) begin
        ptr_r[jp] <= `DDA_ZERO_AW;
      end
    end else begin
      if (ds_go) begin
        ptr_r[ds_pi] <= ds_nxt;
      end
      if (du_req_i) begin
        ptr_r[du_pi] <= du_nxt;
      end
      if (ld_ptr) begin
        ptr_r[ld_i] <= ld_data_i;
      end
    end
  end

  // buffer base follows the last pointer write, not the stepping
  integer jb;
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (jb = 0; jb < NSLOT; jb = jb + 1) begin
        base_r[jb] <= `DDA_ZERO_AW;
      end
    end else if (ld_ptr) begin
      base_r[ld_i] <= ld_data_i;
    end
  end

  integer jm;
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (jm = 0; jm < NSLOT; jm = jm + 1) begin
        mod_r[jm] <= `DDA_ZERO_AW;
      end
    end else if (ld_mod) begin
      mod_r[ld_i] <= ld_data_i;
    end
  end

  // zero length leaves that pointer in linear addressing
  integer jl;
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (jl = 0; jl < NSLOT; jl = jl + 1) begin
        len_r[jl] <= `DDA_ZERO_AW;
      end
    end else if (ld_len) begin
      len_r[ld_i] <= ld_data_i;
    end
  end

  // data side output: the address used, before the step
  always @(posedge clk_i) begin
    if (reset_i) begin
      dm_addr_r  <= `DDA_ZERO_AW;
      dm_valid_r <= `DDA_BIT_CLR;
      sp_grant_r <= `DDA_BIT_CLR;
    end else begin
      dm_addr_r  <= rev_on ? ds_rev : ds_cur;
      dm_valid_r <= ds_go;
      sp_grant_r <= sp_go;
    end
  end

  // dual side output: both buses see the address, bank picks valid
  always @(posedge clk_i) begin
    if (reset_i) begin
      pm_addr_r     <= `DDA_ZERO_AW;
      du_dm_addr_r  <= `DDA_ZERO_AW;
      pm_valid_r    <= `DDA_BIT_CLR;
      du_dm_valid_r <= `DDA_BIT_CLR;
    end else begin
      pm_addr_r     <= du_cur;
      du_dm_addr_r  <= du_cur;
      pm_valid_r    <= du_req_i & (du_bank_i == `DDA_BANK_PM);
      du_dm_valid_r <= du_req_i & (du_bank_i == `DDA_BANK_DM);
    end
  end

  assign data_memory_address_bus_o    = dm_addr_r;
  assign dm_valid_o                   = dm_valid_r;
  assign program_memory_address_bus_o = pm_addr_r;
  assign pm_valid_o                   = pm_valid_r;
  assign du_dm_address_o              = du_dm_addr_r;
  assign du_dm_valid_o                = du_dm_valid_r;
  assign sp_grant_o                   = sp_grant_r;
endmodule // dda_dual

/* dv/dag_dual_properties.sv */
// port assertions for the dual address generators
`timescale 1ns/1ps
module dda_dual_properties (
  input wire clk_i,
  input wire reset_i,
  input wire ds_req_i,
  input wire du_req_i,
  input wire du_bank_i,
  input wire sp_req_i,
  input wire dm_valid_o,
  input wire pm_valid_o,
  input wire du_dm_valid_o,
  input wire sp_grant_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_dm_pulse: assert property
    (ds_req_i |=> dm_valid_o)
    else $error("dm valid missing");
  chk_pm_bank: assert property
    (du_req_i && du_bank_i |=> pm_valid_o)
    else $error("pm valid missing");
  chk_du_dm: assert property
    (du_req_i && !du_bank_i |=> du_dm_valid_o)
    else $error("dual dm valid missing");
  chk_both_gens: assert property
    (ds_req_i && du_req_i |=> dm_valid_o)
    else $error("parallel access lost");
  chk_sp_grant: assert property
    (sp_req_i && !ds_req_i |=> sp_grant_o)
    else $error("serial grant missing");
  chk_sp_refused: assert property
    (ds_req_i |=> !sp_grant_o)
    else $error("serial beat core");
  chk_dm_idle: assert property
    (!ds_req_i && !sp_req_i |=> !dm_valid_o)
    else $error("spurious dm valid");
  chk_pm_idle: assert property
    (!du_req_i |=> !pm_valid_o && !du_dm_valid_o)
    else $error("spurious dual valid");
  cover property (ds_req_i && du_req_i && du_bank_i);
  cover property (sp_req_i && !ds_req_i);
  cover property (du_req_i && !du_bank_i);
endmodule // dda_dual_properties
bind dda_dual dda_dual_properties u_props (
  .clk_i         (clk_i),
  .reset_i       (reset_i),
  .ds_req_i      (ds_req_i),
  .du_req_i      (du_req_i),
  .du_bank_i     (du_bank_i),
  .sp_req_i      (sp_req_i),
  .dm_valid_o    (dm_valid_o),
  .pm_valid_o    (pm_valid_o),
  .du_dm_valid_o (du_dm_valid_o),
  .sp_grant_o    (sp_grant_o)
);

/* dv/dag_mem_model.sv */
// program memory side: latches each address it is handed
`timescale 1ns/1ps
module dda_mem_model (
  input  wire        clk_i,
  input  wire        pm_valid_i,
  input  wire [13:0] pm_addr_i,
  output reg  [13:0] pm_seen_o
);
  initial pm_seen_o = 14'h0000;
  always @(posedge clk_i) begin
    if (pm_valid_i) pm_seen_o <= pm_addr_i;
  end
endmodule // dda_mem_model

/* dv/tb_top.sv */
// scenario bench for the dual address generators
`timescale 1ns/1ps
module tb_top;
  reg clk_i = 0, reset_i = 1, ds_req_i = 0, ds_bitrev_i = 0, du_req_i = 0;
  reg du_bank_i = 0, sp_req_i = 0, ld_gen_i = 0;
  reg [1:0] ld_sel_i = 0, ld_idx_i = 0, ds_ptr_i = 0, ds_mod_i = 0;
  reg [1:0] du_ptr_i = 0, du_mod_i = 0, sp_ptr_i = 0, sp_mod_i = 0;
  reg [13:0] ld_data_i = 14'h0000;
  wire [13:0] data_memory_address_bus_o, program_memory_address_bus_o;
  wire [13:0] du_dm_address_o, pm_seen;
  wire dm_valid_o, pm_valid_o, du_dm_valid_o, sp_grant_o;
  int bad_count = 0, compares = 0;
  dda_dual DUT (
    .clk_i                        (clk_i),
    .reset_i                      (reset_i),
    .ld_sel_i                     (ld_sel_i),
    .ld_gen_i                     (ld_gen_i),
    .ld_idx_i                     (ld_idx_i),
    .ld_data_i                    (ld_data_i),
    .ds_req_i                     (ds_req_i),
    .ds_ptr_i                     (ds_ptr_i),
    .ds_mod_i                     (ds_mod_i),
    .ds_bitrev_i                  (ds_bitrev_i),
    .du_req_i                     (du_req_i),
    .du_ptr_i                     (du_ptr_i),
    .du_mod_i                     (du_mod_i),
    .du_bank_i                    (du_bank_i),
    .sp_req_i                     (sp_req_i),
    .sp_ptr_i                     (sp_ptr_i),
    .sp_mod_i                     (sp_mod_i),
    .data_memory_address_bus_o    (data_memory_address_bus_o),
    .dm_valid_o                   (dm_valid_o),
    .program_memory_address_bus_o (program_memory_address_bus_o),
    .pm_valid_o                   (pm_valid_o),
    .du_dm_address_o              (du_dm_address_o),
    .du_dm_valid_o                (du_dm_valid_o),
    .sp_grant_o                   (sp_grant_o)
  );
  dda_mem_model MEM (
    .clk_i      (clk_i),
    .pm_valid_i (pm_valid_o),
    .pm_addr_i  (program_memory_address_bus_o),
    .pm_seen_o  (pm_seen)
  );
  initial forever #20 clk_i = ~clk_i;
  task complete_run;
    $display("checks %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [13:0] g, input [13:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task ld(input [1:0] s, input g, input [1:0] i, input [13:0] d);
    @(posedge clk_i); ld_sel_i <= s; ld_gen_i <= g; ld_idx_i <= i;
    ld_data_i <= d;
    @(posedge clk_i); ld_sel_i <= 2'h0;
  endtask
  task acc(input [1:0] p, input [1:0] m, input r, input [13:0] e);
    @(posedge clk_i); ds_req_i <= 1; ds_ptr_i <= p; ds_mod_i <= m;
    ds_bitrev_i <= r;
    @(posedge clk_i); ds_req_i <= 0;
    #1 chk(data_memory_address_bus_o, e);
  endtask
  task t_step;
    ld(2'h1, 0, 2'h0, 14'h0010);
    ld(2'h2, 0, 2'h1, 14'h0003);
    acc(2'h0, 2'h1, 0, 14'h0010);
    acc(2'h0, 2'h1, 0, 14'h0013);
    $display("step done");
  endtask
  task t_circ;
    ld(2'h1, 0, 2'h1, 14'h0020);
    ld(2'h3, 0, 2'h1, 14'h0004);
    ld(2'h2, 0, 2'h0, 14'h0002);
    acc(2'h1, 2'h0, 0, 14'h0020);
    acc(2'h1, 2'h0, 0, 14'h0022);
    acc(2'h1, 2'h0, 0, 14'h0020);
    ld(2'h2, 0, 2'h3, 14'h3FFE);
    acc(2'h1, 2'h3, 0, 14'h0022);
    acc(2'h1, 2'h3, 0, 14'h0020);
    acc(2'h1, 2'h3, 0, 14'h0022);
    ld(2'h1, 0, 2'h2, 14'h0001);
    acc(2'h2, 2'h0, 1, 14'h2000);
    $display("circular and reverse done");
  endtask
  task t_dual;
    ld(2'h1, 1, 2'h0, 14'h0100);
    @(posedge clk_i); du_req_i <= 1; du_bank_i <= 1; ds_req_i <= 1;
    ds_bitrev_i <= 0; sp_req_i <= 1;
    @(posedge clk_i); du_bank_i <= 0; ds_req_i <= 0;
    #1 chk(data_memory_address_bus_o, 14'h0003);
    chk({13'h0000, sp_grant_o}, 14'h0000);
    @(posedge clk_i); du_req_i <= 0; sp_req_i <= 0;
    #1 chk(pm_seen, 14'h0100);
    chk({13'h0000, sp_grant_o}, 14'h0001);
    chk(data_memory_address_bus_o, 14'h0016);
    chk(du_dm_address_o, 14'h0100);
    $display("dual done");
  endtask
  initial begin
    #20000 bad_count++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    t_step;
    t_circ;
    t_dual;
    complete_run;
  end
endmodule // tb_top
